// ==== ubfc_uart.sv ====
// Summary of operation
// - Divisor high half is buffered; working divisor changes on low write.
// - Zero divisor stops the baud generator entirely.
// - Divisor 1..8191 gives bit rate of clock over sixteen times divisor.
// - Generator stays off after reset until rx or tx enable is written one.
// - High register bits 4:0 are divisor 12:8; low register is divisor 7:0.
// - Line-break enable bit routes the break flag to the interrupt.
// - Receive-edge enable bit routes the edge flag to the interrupt.
// - Loopback feeds transmitter into receiver and ignores the receive pin.
// - Stop-in-wait freezes the engines while the processor waits.
// - Under loopback, receiver source chooses internal loop or single wire.
// - Nine-bit select adds a ninth data bit to the frame.
// - Wake select picks idle-line or address-mark wakeup.
// - Idle count type starts idle counting after start or after stop bit.
// - Parity enable makes the top data bit the generated and checked parity.
// - Parity odd select makes the total count of ones odd, else even.
// - Eight byte-wide registers cover baud, options, status and data.
// - Loopback releases the receive pin even while receiving is enabled.
// - Single-wire direction bit decides whether the transmit pin drives.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ubfc_cfg.svh"

module ubfc_uart #(
    parameter int DIV_W = 13,
    parameter int IDLE_BITS = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor wait state
    input wire logic cpu_wait,
    // Serial pins
    input wire logic rxd_in,
    input wire logic txd_in,
    output logic txd_out,
    output logic txd_oe,
    output logic rxd_owned,
    // Interrupt
    output logic irq
);

    // Software registers
    logic [7:0] baud_divisor_high;
    logic [7:0] baud_divisor_low;
    logic [7:0] serial_option_control;
    logic [7:0] ctrl2;
    logic [4:0] high_buffer;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic gen_armed;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic parity_err;
    logic frame_err;
    logic idle_seen;
    logic standby;

    // Register decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && penable && !pwrite;
    wire wr_high = wr_en && hit(paddr, `UBFC_OFF_BAUD_HIGH);
    wire wr_low = wr_en && hit(paddr, `UBFC_OFF_BAUD_LOW);
    wire wr_opt = wr_en && hit(paddr, `UBFC_OFF_OPTION);
    wire wr_c2 = wr_en && hit(paddr, `UBFC_OFF_CTRL2);
    wire wr_data = wr_en && hit(paddr, `UBFC_OFF_DATA);
    wire wr_istat = wr_en && hit(paddr, `UBFC_OFF_IRQ_STAT);
    wire wr_imask = wr_en && hit(paddr, `UBFC_OFF_IRQ_MASK);
    wire rd_data = rd_en && hit(paddr, `UBFC_OFF_DATA);
    wire addr_ok = hit(paddr, `UBFC_OFF_BAUD_HIGH) || hit(paddr, `UBFC_OFF_BAUD_LOW)
        || hit(paddr, `UBFC_OFF_OPTION) || hit(paddr, `UBFC_OFF_CTRL2)
        || hit(paddr, `UBFC_OFF_STATUS) || hit(paddr, `UBFC_OFF_DATA)
        || hit(paddr, `UBFC_OFF_IRQ_STAT) || hit(paddr, `UBFC_OFF_IRQ_MASK);

    // Option fields
    wire loopback_select = serial_option_control[`UBFC_OPT_LOOP];
    wire stop_in_wait = serial_option_control[`UBFC_OPT_WAIT_STOP];
    wire receiver_source = serial_option_control[`UBFC_OPT_RX_SRC];
    wire nine_bit = serial_option_control[`UBFC_OPT_NINE_BIT];
    wire wake_addr_mark = serial_option_control[`UBFC_OPT_WAKE];
    wire idle_count_type = serial_option_control[`UBFC_OPT_IDLE_TYPE];
    wire parity_enable = serial_option_control[`UBFC_OPT_PAR_EN];
    wire parity_odd_select = serial_option_control[`UBFC_OPT_PAR_ODD];
    wire tx_enable = ctrl2[`UBFC_C2_TX_EN];
    wire rx_enable = ctrl2[`UBFC_C2_RX_EN];
    wire single_wire_dir = ctrl2[`UBFC_C2_TX_DIR];
    wire line_break_irq_en = baud_divisor_high[`UBFC_BH_BREAK_IE];
    wire rx_edge_irq_en = baud_divisor_high[`UBFC_BH_EDGE_IE];

    wire [DIV_W-1:0] baud_modulo = DIV_W'({baud_divisor_high[`UBFC_BH_DIV_MSB:0],
        baud_divisor_low});
    wire frozen = stop_in_wait && cpu_wait;
    wire gen_run = gen_armed && (baud_modulo != '0) && !frozen;

    // Register writes; high divisor half waits for the low write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            baud_divisor_high <= `UBFC_RST_BAUD_HIGH;
            baud_divisor_low <= `UBFC_RST_BAUD_LOW;
            high_buffer <= '0;
            serial_option_control <= `UBFC_RST_OPTION;
            ctrl2 <= `UBFC_RST_CTRL2;
            irq_mask <= '0;
            gen_armed <= 1'b0;
        end else begin
            if (wr_high) begin
                high_buffer <= pwdata[`UBFC_BH_DIV_MSB:0];
                baud_divisor_high[7:5] <= pwdata[7:5];
            end
            if (wr_low) begin
                baud_divisor_low <= pwdata[7:0];
                baud_divisor_high[`UBFC_BH_DIV_MSB:0] <= high_buffer;
            end
            if (wr_opt) serial_option_control <= pwdata[7:0];
            if (wr_c2) ctrl2 <= pwdata[7:0];
            if (wr_c2 && (pwdata[`UBFC_C2_TX_EN] || pwdata[`UBFC_C2_RX_EN])) begin
                gen_armed <= 1'b1;
            end
            if (wr_imask) irq_mask <= pwdata[3:0];
        end
    end

    // Baud generator: one tick per divisor count, sixteen ticks per bit
    logic [DIV_W-1:0] baud_cnt;
    logic tick;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            baud_cnt <= '0;
            tick <= 1'b0;
        end else if (!gen_run || wr_low) begin
            baud_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (baud_cnt >= baud_modulo - `UBFC_DIV_ONE);
            baud_cnt <= (baud_cnt >= baud_modulo - `UBFC_DIV_ONE) ? '0
                : baud_cnt + `UBFC_DIV_ONE;
        end
    end

    // Frame helpers
    wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;

    function automatic logic par_of(input logic [8:0] d, input logic nine, input logic odd);
        logic p;
        p = nine ? ^d[7:0] : ^d[6:0];
        return p ^ odd;
    endfunction

    // Transmitter
    ubfc_pkg::ubfc_tx_state_t tx_state;
    logic [8:0] tx_shift;
    logic [3:0] tx_sub;
    logic [3:0] tx_idx;
    logic tx_line;
    logic tx_busy;
    logic [8:0] tx_hold;
    logic tx_pend;
    logic tx_done_ev;
    wire tx_bit_end = tick && (tx_sub == `UBFC_TICKS_PER_BIT);
    wire [8:0] tx_frame = parity_enable ? (nine_bit
        ? {par_of(tx_hold, 1'b1, parity_odd_select), tx_hold[7:0]}
        : {1'b0, par_of(tx_hold, 1'b0, parity_odd_select), tx_hold[6:0]})
        : tx_hold;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_state <= ubfc_pkg::UBFC_TX_IDLE;
            tx_shift <= '0;
            tx_sub <= '0;
            tx_idx <= '0;
            tx_line <= 1'b1;
            tx_hold <= '0;
            tx_pend <= 1'b0;
            tx_done_ev <= 1'b0;
        end else begin
            tx_done_ev <= 1'b0;
            if (wr_data) begin
                tx_hold <= pwdata[8:0];
                tx_pend <= 1'b1;
            end
            if (tick) tx_sub <= tx_sub + 4'h1;
            unique case (tx_state)
                ubfc_pkg::UBFC_TX_IDLE: begin
                    tx_line <= 1'b1;
                    if (tx_pend && tx_enable && tick && !wr_data) begin
                        tx_shift <= tx_frame;
                        tx_pend <= 1'b0;
                        tx_sub <= '0;
                        tx_line <= 1'b0;
                        tx_state <= ubfc_pkg::UBFC_TX_START;
                    end
                end
                ubfc_pkg::UBFC_TX_START: begin
                    if (tx_bit_end) begin
                        tx_line <= tx_shift[0];
                        tx_idx <= '0;
                        tx_state <= ubfc_pkg::UBFC_TX_DATA;
                    end
                end
                ubfc_pkg::UBFC_TX_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_idx == last_bit) begin
                            tx_line <= 1'b1;
                            tx_state <= ubfc_pkg::UBFC_TX_STOP;
                        end else begin
                            tx_shift <= tx_shift >> 1;
                            tx_line <= tx_shift[1];
                            tx_idx <= tx_idx + 4'h1;
                        end
                    end
                end
                ubfc_pkg::UBFC_TX_STOP: begin
                    if (tx_bit_end) begin
                        tx_done_ev <= 1'b1;
                        tx_state <= ubfc_pkg::UBFC_TX_IDLE;
                    end
                end
            endcase
        end
    end
    assign tx_busy = (tx_state != ubfc_pkg::UBFC_TX_IDLE);

    // Receiver input routing
    wire rx_src = !loopback_select ? rxd_in
        : (receiver_source ? txd_in : tx_line);

    // Receiver
    ubfc_pkg::ubfc_rx_state_t rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_sub;
    logic [3:0] rx_idx;
    logic rx_prev;
    logic rx_full_ev;
    logic edge_ev;
    logic break_ev;
    logic [3:0] idle_cnt;
    logic idle_armed;
    wire rx_sample = tick && (rx_sub == `UBFC_TICK_MID);
    wire [8:0] rx_word = nine_bit ? rx_shift : {1'b0, rx_shift[8:1]};
    wire rx_par_bad = parity_enable && (par_of(rx_word, nine_bit, parity_odd_select)
        != (nine_bit ? rx_word[8] : rx_word[7]));
    wire wake_mark = nine_bit ? rx_word[8] : rx_word[7];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_state <= ubfc_pkg::UBFC_RX_IDLE;
            rx_shift <= '0;
            rx_sub <= '0;
            rx_idx <= '0;
            rx_prev <= 1'b1;
            rx_data <= '0;
            rx_ninth <= 1'b0;
            parity_err <= 1'b0;
            frame_err <= 1'b0;
            rx_full_ev <= 1'b0;
            edge_ev <= 1'b0;
            break_ev <= 1'b0;
            standby <= 1'b0;
            idle_cnt <= '0;
            idle_armed <= 1'b0;
            idle_seen <= 1'b0;
        end else begin
            rx_full_ev <= 1'b0;
            edge_ev <= 1'b0;
            break_ev <= 1'b0;
            rx_prev <= rx_src;
            edge_ev <= rx_enable && rx_prev && !rx_src;
            if (wr_c2) standby <= pwdata[0];
            if (rd_data) idle_seen <= 1'b0;
            if (tick) rx_sub <= rx_sub + 4'h1;
            // Idle counting, one per high bit time
            if (rx_sample && idle_armed && rx_src) begin
                idle_cnt <= idle_cnt + 4'h1;
                if (idle_cnt == 4'(IDLE_BITS - 1)) begin
                    idle_seen <= 1'b1;
                    idle_armed <= 1'b0;
                    if (!wake_addr_mark) standby <= 1'b0;
                end
            end
            unique case (rx_state)
                ubfc_pkg::UBFC_RX_IDLE: begin
                    if (rx_enable && tick && !rx_src) begin
                        rx_sub <= '0;
                        rx_state <= ubfc_pkg::UBFC_RX_START;
                    end
                end
                ubfc_pkg::UBFC_RX_START: begin
                    if (rx_sample) begin
                        rx_idx <= '0;
                        idle_cnt <= '0;
                        idle_armed <= !idle_count_type;
                        rx_state <= rx_src ? ubfc_pkg::UBFC_RX_IDLE
                            : ubfc_pkg::UBFC_RX_DATA;
                    end
                end
                ubfc_pkg::UBFC_RX_DATA: begin
                    if (rx_sample) begin
                        if (!rx_src) idle_cnt <= '0;
                        rx_shift <= {rx_src, rx_shift[8:1]};
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == last_bit) rx_state <= ubfc_pkg::UBFC_RX_STOP;
                    end
                end
                ubfc_pkg::UBFC_RX_STOP: begin
                    if (rx_sample) begin
                        if (idle_count_type) begin
                            idle_cnt <= '0;
                            idle_armed <= 1'b1;
                        end
                        break_ev <= !rx_src && (rx_word == '0);
                        if (wake_addr_mark && wake_mark) standby <= 1'b0;
                        if (!standby || (wake_addr_mark && wake_mark)) begin
                            rx_data <= rx_word[7:0];
                            rx_ninth <= rx_word[8];
                            parity_err <= rx_par_bad;
                            frame_err <= !rx_src;
                            rx_full_ev <= 1'b1;
                        end
                        rx_state <= ubfc_pkg::UBFC_RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Sticky event flags; a new event wins over a write-one clear
    logic [3:0] ev_vec;
    assign ev_vec[`UBFC_IRQ_BREAK] = break_ev;
    assign ev_vec[`UBFC_IRQ_EDGE] = edge_ev;
    assign ev_vec[`UBFC_IRQ_TX_DONE] = tx_done_ev;
    assign ev_vec[`UBFC_IRQ_RX_FULL] = rx_full_ev;
    wire [3:0] clr_vec = wr_istat ? pwdata[3:0] : 4'h0;
    wire [3:0] next_irq_stat = (irq_stat & ~clr_vec) | ev_vec;
    wire [3:0] en_vec = irq_mask & {2'b11, rx_edge_irq_en, line_break_irq_en};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & en_vec);
        end
    end

    // Pin control; single wire turns the pin by direction bit
    wire next_txd_oe = tx_enable && (!loopback_select || (receiver_source
        && single_wire_dir));
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            txd_out <= 1'b1;
            txd_oe <= 1'b0;
            rxd_owned <= 1'b0;
        end else begin
            txd_out <= tx_line;
            txd_oe <= next_txd_oe || tx_busy && !loopback_select;
            rxd_owned <= rx_enable && !loopback_select;
        end
    end

    // Status read view
    wire [7:0] status_view = {tx_busy, tx_pend, rx_ninth, standby, idle_seen,
        frame_err, parity_err, gen_run};

    // APB read mux; registered answer, no wait state
    wire [7:0] rd_mux = hit(paddr, `UBFC_OFF_BAUD_HIGH) ? baud_divisor_high
        : hit(paddr, `UBFC_OFF_BAUD_LOW) ? baud_divisor_low
        : hit(paddr, `UBFC_OFF_OPTION) ? serial_option_control
        : hit(paddr, `UBFC_OFF_CTRL2) ? ctrl2
        : hit(paddr, `UBFC_OFF_STATUS) ? status_view
        : hit(paddr, `UBFC_OFF_DATA) ? rx_data
        : hit(paddr, `UBFC_OFF_IRQ_STAT) ? {4'h0, irq_stat}
        : hit(paddr, `UBFC_OFF_IRQ_MASK) ? {4'h0, irq_mask} : 8'h00;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= {24'h000000, rd_mux};
        end
    end
endmodule

// ==== ubfc_cfg.svh ====
`ifndef UBFC_CFG_SVH
`define UBFC_CFG_SVH

// Register byte addresses on APB
`define UBFC_OFF_BAUD_HIGH   12'h000
`define UBFC_OFF_BAUD_LOW    12'h004
`define UBFC_OFF_OPTION      12'h008
`define UBFC_OFF_CTRL2       12'h00c
`define UBFC_OFF_STATUS      12'h010
`define UBFC_OFF_DATA        12'h014
`define UBFC_OFF_IRQ_STAT    12'h018
`define UBFC_OFF_IRQ_MASK    12'h01c

// Reset values
`define UBFC_RST_BAUD_HIGH   8'h00
`define UBFC_RST_BAUD_LOW    8'h04
`define UBFC_RST_OPTION      8'h00
`define UBFC_RST_CTRL2       8'h00

// High baud register fields
`define UBFC_BH_BREAK_IE     7
`define UBFC_BH_EDGE_IE      6
`define UBFC_BH_DIV_MSB      4

// Option register fields
`define UBFC_OPT_LOOP        7
`define UBFC_OPT_WAIT_STOP   6
`define UBFC_OPT_RX_SRC      5
`define UBFC_OPT_NINE_BIT    4
`define UBFC_OPT_WAKE        3
`define UBFC_OPT_IDLE_TYPE   2
`define UBFC_OPT_PAR_EN      1
`define UBFC_OPT_PAR_ODD     0

// Second control register fields
`define UBFC_C2_TX_EN        3
`define UBFC_C2_RX_EN        2
`define UBFC_C2_TX_DIR       1

// Interrupt status bits
`define UBFC_IRQ_BREAK       0
`define UBFC_IRQ_EDGE        1
`define UBFC_IRQ_TX_DONE     2
`define UBFC_IRQ_RX_FULL     3

// Serial timing
`define UBFC_TICKS_PER_BIT   4'hf
`define UBFC_TICK_MID        4'h7
`define UBFC_DIV_ONE         13'h0001

`endif

// ==== ubfc_pkg.sv ====
package ubfc_pkg;
    // Transmit engine states, Gray coded along the frame
    typedef enum logic [1:0] {
        UBFC_TX_IDLE  = 2'b00,
        UBFC_TX_START = 2'b01,
        UBFC_TX_DATA  = 2'b11,
        UBFC_TX_STOP  = 2'b10
    } ubfc_tx_state_t;

    // Receive engine states, Gray coded along the frame
    typedef enum logic [1:0] {
        UBFC_RX_IDLE  = 2'b00,
        UBFC_RX_START = 2'b01,
        UBFC_RX_DATA  = 2'b11,
        UBFC_RX_STOP  = 2'b10
    } ubfc_rx_state_t;
endpackage

// ==== ubfc_uart_sva.sv ====
`timescale 1ns/1ps
`include "ubfc_cfg.svh"

module ubfc_uart_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial pins
    input wire logic txd_out,
    input wire logic txd_oe,
    input wire logic rxd_owned
);
    logic [7:0] opt, c2, hb;
    logic [12:0] div;
    logic last_txd;
    logic [17:0] run;
    wire logic wr_en = psel && penable && pwrite && pready;
    wire logic single_rx = opt[7] && opt[5] && !c2[1];
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Shadow of writes; divisor moves on a low write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            opt <= 8'h00;
            c2 <= 8'h00;
            hb <= 8'h00;
            div <= 13'h0004;
        end else if (wr_en) begin
            if (paddr == `UBFC_OFF_BAUD_HIGH) hb <= pwdata[7:0];
            if (paddr == `UBFC_OFF_BAUD_LOW) div <= {hb[4:0], pwdata[7:0]};
            if (paddr == `UBFC_OFF_OPTION) opt <= pwdata[7:0];
            if (paddr == `UBFC_OFF_CTRL2) c2 <= pwdata[7:0];
        end
    end

    // Length of the present transmit level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            last_txd <= 1'b1;
            run <= 18'h00000;
        end else begin
            last_txd <= txd_out;
            run <= (txd_out != last_txd) ? 18'h00001 : run + 18'h00001;
        end
    end

    property p_ready_next; psel && !penable |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
    property p_ready_once; pready |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready held too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_rd_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_unmapped; psel && !penable && paddr > `UBFC_OFF_IRQ_MASK |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_loop_free; opt[7] && $past(opt[7]) |-> !rxd_owned; endproperty
    a_loop_free: assert property (p_loop_free) else $error("pin kept in loop");
    property p_swire_rx; single_rx && $past(single_rx) |-> !txd_oe; endproperty
    a_swire_rx: assert property (p_swire_rx) else $error("shared pin driven");
    property p_low_run; !last_txd && txd_out && div != 13'h0 |-> run % {1'b0, div, 4'h0} == 0; endproperty
    a_low_run: assert property (p_low_run) else $error("bit time wrong");
endmodule

// ==== ubfc_remote.sv ====
`timescale 1ns/1ps

module ubfc_remote (
    // Clock
    input wire logic mclk,
    // Serial line
    input wire logic line_in,
    output logic line_out
);
    // Idle line is high
    initial line_out = 1'b1;

    // Hold the line at a level
    task automatic level(input logic v);
        line_out <= v;
    endtask

    // Start, data LSB first, stop; bt clocks a bit
    task automatic send(input logic [10:0] bits, input int n, input int bt);
        line_out <= 1'b0;
        repeat (bt) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (bt) @(posedge mclk);
        end
        line_out <= 1'b1;
        repeat (bt) @(posedge mclk);
    endtask

    // Sample mid-bit, LSB first
    task automatic recv(output logic [8:0] d, input int n, input int bt);
        int w = 0;
        d = 9'h000;
        while (line_in !== 1'b0 && w < 4000) begin
            @(posedge mclk);
            w++;
        end
        repeat (bt / 2) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            repeat (bt) @(posedge mclk);
            d[i] = line_in;
        end
    endtask
endmodule

// ==== test_ubfc_uart.sv ====
`timescale 1ns/1ps
`include "ubfc_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_ubfc_uart;
    // Bench counters and design pins
    int miscompares = 0, num_checks = 0;
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_wait = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, txd_out, txd_oe, rxd_owned, irq, line, err;
    logic [8:0] got;
    // Far end owns the transmit pin when undriven
    wire logic pin = txd_oe ? txd_out : line;

    ubfc_uart ubfc_uart_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_wait(cpu_wait), .rxd_in(line), .txd_in(pin),
        .txd_out(txd_out), .txd_oe(txd_oe), .rxd_owned(rxd_owned), .irq(irq));
    ubfc_remote ubfc_remote_i (.mclk(mclk), .line_in(pin), .line_out(line));

    // 25 MHz
    initial forever #20 mclk = ~mclk;

    // Verdict and end of run
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer, then an idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        if (n == 40) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [8:0] d);
        apb(1'b1, a, {23'h0, d});
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd[7:0] & m, e)
    endtask
    // Send a word and judge what the far end saw
    task automatic txchk(input logic [8:0] d, input int n, input int bt, input logic [8:0] e);
        wr(`UBFC_OFF_DATA, d);
        ubfc_remote_i.recv(got, n, bt);
        `CHK(got, e)
        repeat (bt) @(posedge mclk);
    endtask
    // Expected line word, parity in the top data bit
    function automatic logic [8:0] expv(input logic [7:0] o, input logic [8:0] d);
        logic [8:0] m;
        m = o[4] ? d : {1'b0, d[7:0]};
        if (o[1] && o[4]) m[8] = ^m[7:0] ^ o[0];
        if (o[1] && !o[4]) m[7] = ^m[6:0] ^ o[0];
        return m;
    endfunction

    task automatic t_reset();
        rchk(`UBFC_OFF_BAUD_HIGH, 8'hff, `UBFC_RST_BAUD_HIGH);
        rchk(`UBFC_OFF_BAUD_LOW, 8'hff, `UBFC_RST_BAUD_LOW);
        rchk(`UBFC_OFF_STATUS, 8'h01, 8'h00);
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        wr(`UBFC_OFF_OPTION, 9'h0ff);
        rchk(`UBFC_OFF_OPTION, 8'hff, 8'hff);
        wr(`UBFC_OFF_OPTION, 9'h000);
        wr(`UBFC_OFF_CTRL2, 9'h008);
        rchk(`UBFC_OFF_STATUS, 8'h01, 8'h01);
    endtask
    task automatic t_divisor();
        wr(`UBFC_OFF_BAUD_LOW, 9'h000);
        rchk(`UBFC_OFF_STATUS, 8'h01, 8'h00);
        wr(`UBFC_OFF_BAUD_HIGH, 9'h001);
        rchk(`UBFC_OFF_STATUS, 8'h01, 8'h00);
        wr(`UBFC_OFF_BAUD_LOW, 9'h000);
        rchk(`UBFC_OFF_STATUS, 8'h01, 8'h01);
        wr(`UBFC_OFF_BAUD_HIGH, 9'h000);
        wr(`UBFC_OFF_BAUD_LOW, 9'h002);
        txchk(9'h0c5, 8, 32, 9'h0c5);
        wr(`UBFC_OFF_BAUD_LOW, 9'h001);
    endtask
    task automatic t_frames();
        logic [7:0] modes [6] = '{8'h00, 8'h03, 8'h0e, 8'h10, 8'h12, 8'h1d};
        foreach (modes[i]) begin
            wr(`UBFC_OFF_OPTION, {1'b0, modes[i]});
            txchk(9'h0a7, modes[i][4] ? 9 : 8, 16, expv(modes[i], 9'h0a7));
        end
    endtask
    task automatic t_receive();
        wr(`UBFC_OFF_OPTION, 9'h002);
        wr(`UBFC_OFF_CTRL2, 9'h00c);
        @(posedge mclk);
        `CHK(rxd_owned, 1'b1)
        ubfc_remote_i.send(11'h001, 8, 16);
        rchk(`UBFC_OFF_STATUS, 8'h02, 8'h02);
        rchk(`UBFC_OFF_DATA, 8'h7f, 8'h01);
        ubfc_remote_i.send(11'h081, 8, 16);
        rchk(`UBFC_OFF_DATA, 8'h7f, 8'h01);
    endtask
    task automatic t_loop();
        wr(`UBFC_OFF_OPTION, 9'h080);
        ubfc_remote_i.level(1'b0);
        wr(`UBFC_OFF_DATA, 9'h03c);
        repeat (200) @(posedge mclk);
        rchk(`UBFC_OFF_DATA, 8'hff, 8'h3c);
        `CHK(rxd_owned, 1'b0)
        ubfc_remote_i.level(1'b1);
        wr(`UBFC_OFF_OPTION, 9'h0a0);
        wr(`UBFC_OFF_CTRL2, 9'h004);
        ubfc_remote_i.send(11'h05a, 8, 16);
        `CHK(txd_oe, 1'b0)
        rchk(`UBFC_OFF_DATA, 8'hff, 8'h5a);
        wr(`UBFC_OFF_CTRL2, 9'h00e);
        txchk(9'h066, 8, 16, 9'h066);
    endtask
    task automatic t_irq();
        wr(`UBFC_OFF_OPTION, 9'h000);
        wr(`UBFC_OFF_CTRL2, 9'h004);
        wr(`UBFC_OFF_BAUD_HIGH, 9'h040);
        wr(`UBFC_OFF_IRQ_MASK, 9'h000);
        wr(`UBFC_OFF_IRQ_STAT, 9'h0ff);
        ubfc_remote_i.send(11'h0f0, 8, 16);
        `CHK(irq, 1'b0)
        wr(`UBFC_OFF_IRQ_MASK, 9'h003);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b1)
        wr(`UBFC_OFF_IRQ_STAT, 9'h002);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0)
        wr(`UBFC_OFF_BAUD_HIGH, 9'h080);
        ubfc_remote_i.send(11'h000, 10, 24);
        `CHK(irq, 1'b1)
        wr(`UBFC_OFF_IRQ_STAT, 9'h0ff);
        wr(`UBFC_OFF_BAUD_HIGH, 9'h000);
        ubfc_remote_i.send(11'h000, 10, 24);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_wait();
        int low = 0;
        wr(`UBFC_OFF_CTRL2, 9'h008);
        wr(`UBFC_OFF_OPTION, 9'h040);
        cpu_wait <= 1'b1;
        wr(`UBFC_OFF_DATA, 9'h055);
        repeat (300) begin
            @(posedge mclk);
            if (txd_out !== 1'b1) low++;
        end
        `CHK(low, 0)
        cpu_wait <= 1'b0;
        ubfc_remote_i.recv(got, 8, 16);
        `CHK(got, 9'h055)
        repeat (16) @(posedge mclk);
        wr(`UBFC_OFF_OPTION, 9'h000);
        cpu_wait <= 1'b1;
        txchk(9'h033, 8, 16, 9'h033);
        cpu_wait <= 1'b0;
    endtask

    // Watchdog, well past the needed run
    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        summarize();
    end

    // Reset for 20 clocks, then the scenarios
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_divisor();
        t_frames();
        t_receive();
        t_loop();
        t_irq();
        t_wait();
        summarize();
    end
endmodule

bind ubfc_uart ubfc_uart_sva ubfc_uart_sva_i (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd_out(txd_out), .txd_oe(txd_oe),
    .rxd_owned(rxd_owned));
